/* hdl/frt_pkg.sv */
// frt_pkg: register map, field positions and reset values of the free-run capture/compare timer
// assumes a 32-bit apb slave with one register per aligned word
package frt_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_OCCTRL = 8'h08;
  localparam logic [7:0] OFF_CAPCTRL = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_CMP0 = 8'h20;
  localparam logic [7:0] OFF_CAP0 = 8'h30;
  // ctrl fields
  localparam int CTRL_PRE_LSB = 0;
  localparam int CTRL_HALT = 2;
  localparam int CTRL_CLR = 3;
  localparam int CTRL_CMP0_CLR = 4;
  localparam int CTRL_PAIR = 5;
  localparam logic [5:0] CTRL_RST = 6'h04;
  // occtrl fields: bits 3:0 pin preset level, bits 7:4 pin enable
  localparam int OC_EN_LSB = 4;
  // status/mask bit positions
  localparam int ST_OVF = 0;
  localparam int ST_CMP0 = 1;
  localparam int ST_CAP0 = 5;
  localparam int ST_W = 7;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CMP_RST = 16'hffff;
  localparam logic [3:0] EDGE_RISE = 4'h1;
  localparam logic [3:0] EDGE_FALL = 4'h2;
  // prescaler ratios selected by ctrl[1:0]
  localparam logic [5:0] DIV4 = 6'h03;
  localparam logic [5:0] DIV16 = 6'h0f;
  localparam logic [5:0] DIV32 = 6'h1f;
  localparam logic [5:0] DIV64 = 6'h3f;
endpackage : frt_pkg

/* hdl/frt_timer.sv */
// frt_timer: 16-bit free-run timer with four output compares and two input captures
// assumes capture pins synchronous to clk and an apb master on the same clock
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module frt_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] cap_in,
  output logic [3:0] cmp_out,
  output logic [3:0] cmp_oe,
  output logic irq,
  output logic [1:0] cap_xfer_req
);
  logic rs1_r, rst_sync_n;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rst_sync_n <= rs1_r;
    end
  end

  function automatic logic [5:0] div_of(input logic [1:0] sel);
    case (sel)
      2'd0: div_of = frt_pkg::DIV4;
      2'd1: div_of = frt_pkg::DIV16;
      2'd2: div_of = frt_pkg::DIV32;
      default: div_of = frt_pkg::DIV64;
    endcase
  endfunction : div_of

  logic [5:0] ctrl_r, ctrl_nxt;
  logic [7:0] occ_r, occ_nxt;
  logic [3:0] capc_r, capc_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [5:0] pre_r, pre_nxt;
  logic [15:0] cmp_r [4], cmp_nxt [4];
  logic [15:0] cap_r [2], cap_nxt [2];
  logic [3:0] pin_r, pin_nxt;
  logic [1:0] capd_r;
  logic [frt_pkg::ST_W-1:0] st_r, st_nxt, msk_r, msk_nxt;
  logic [31:0] rd_nxt;
  logic tick, wr, rd, acc, clr_req;
  logic [3:0] match;
  logic [1:0] cap_hit;
  logic [frt_pkg::ST_W-1:0] ev;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign clr_req = wr && paddr == frt_pkg::OFF_CTRL && pwdata[frt_pkg::CTRL_CLR];

  always_comb
  begin
    pre_nxt = pre_r + 6'd1;
    tick = 1'b0;
    if (ctrl_r[frt_pkg::CTRL_HALT])
      pre_nxt = pre_r;
    else if (pre_r >= div_of(ctrl_r[1:0]))
    begin
      pre_nxt = 6'd0;
      tick = 1'b1;
    end
    // match seen once per count value, at the tick that leaves it
    for (int i = 0; i < 4; i++)
      match[i] = tick && cnt_r == cmp_r[i];
    for (int j = 0; j < 2; j++)
      cap_hit[j] = (capc_r[2*j] && cap_in[j] && !capd_r[j]) || (capc_r[2*j+1] && !cap_in[j] && capd_r[j]);
    ev = {cap_hit, match, tick && cnt_r == 16'hffff};
    cnt_nxt = cnt_r;
    if (clr_req || (match[0] && ctrl_r[frt_pkg::CTRL_CMP0_CLR]))
      cnt_nxt = frt_pkg::COUNT_RST;
    else if (wr && paddr == frt_pkg::OFF_COUNT)
      cnt_nxt = pwdata[15:0];
    else if (tick)
      cnt_nxt = cnt_r + 16'd1;
    pin_nxt = pin_r;
    if (ctrl_r[frt_pkg::CTRL_PAIR])
    begin
      pin_nxt[0] = pin_r[0] ^ (match[0] ^ match[1]);
      pin_nxt[2] = pin_r[2] ^ (match[2] ^ match[3]);
    end
    else
      pin_nxt = pin_r ^ match;
    if (wr && paddr == frt_pkg::OFF_OCCTRL)
      pin_nxt = pwdata[3:0];
    ctrl_nxt = ctrl_r;
    occ_nxt = occ_r;
    capc_nxt = capc_r;
    msk_nxt = msk_r;
    for (int i = 0; i < 4; i++)
      cmp_nxt[i] = cmp_r[i];
    if (wr)
    begin
      case (paddr)
        frt_pkg::OFF_CTRL: ctrl_nxt = {pwdata[5:4], 1'b0, pwdata[2:0]};
        frt_pkg::OFF_OCCTRL: occ_nxt = pwdata[7:0];
        frt_pkg::OFF_CAPCTRL: capc_nxt = pwdata[3:0];
        frt_pkg::OFF_MASK: msk_nxt = pwdata[frt_pkg::ST_W-1:0];
        frt_pkg::OFF_CMP0, frt_pkg::OFF_CMP0 + 8'h04, frt_pkg::OFF_CMP0 + 8'h08, frt_pkg::OFF_CMP0 + 8'h0c:
          cmp_nxt[paddr[3:2]] = pwdata[15:0];
        default: ;
      endcase
    end
    // sticky flags: set wins over write-one clear
    st_nxt = st_r;
    if (wr && paddr == frt_pkg::OFF_STATUS)
      st_nxt = st_r & ~pwdata[frt_pkg::ST_W-1:0];
    st_nxt = st_nxt | ev;
    for (int j = 0; j < 2; j++)
      cap_nxt[j] = cap_hit[j] ? cnt_r : cap_r[j];
    case (paddr)
      frt_pkg::OFF_CTRL: rd_nxt = {26'd0, ctrl_r};
      frt_pkg::OFF_COUNT: rd_nxt = {16'd0, cnt_r};
      frt_pkg::OFF_OCCTRL: rd_nxt = {24'd0, occ_r[7:4], pin_r};
      frt_pkg::OFF_CAPCTRL: rd_nxt = {28'd0, capc_r};
      frt_pkg::OFF_STATUS: rd_nxt = {25'd0, st_r};
      frt_pkg::OFF_MASK: rd_nxt = {25'd0, msk_r};
      frt_pkg::OFF_CMP0, frt_pkg::OFF_CMP0 + 8'h04, frt_pkg::OFF_CMP0 + 8'h08, frt_pkg::OFF_CMP0 + 8'h0c:
        rd_nxt = {16'd0, cmp_r[paddr[3:2]]};
      frt_pkg::OFF_CAP0, frt_pkg::OFF_CAP0 + 8'h04: rd_nxt = {16'd0, cap_r[paddr[2]]};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_r <= frt_pkg::CTRL_RST;
      occ_r <= 8'h00;
      capc_r <= 4'h0;
      cnt_r <= frt_pkg::COUNT_RST;
      pre_r <= 6'd0;
      pin_r <= 4'h0;
      capd_r <= 2'b00;
      st_r <= '0;
      msk_r <= '0;
      for (int i = 0; i < 4; i++)
        cmp_r[i] <= frt_pkg::CMP_RST;
      for (int j = 0; j < 2; j++)
        cap_r[j] <= 16'h0000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cmp_out <= 4'h0;
      cmp_oe <= 4'h0;
      irq <= 1'b0;
      cap_xfer_req <= 2'b00;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      occ_r <= occ_nxt;
      capc_r <= capc_nxt;
      cnt_r <= cnt_nxt;
      pre_r <= pre_nxt;
      pin_r <= pin_nxt;
      capd_r <= cap_in;
      st_r <= st_nxt;
      msk_r <= msk_nxt;
      for (int i = 0; i < 4; i++)
        cmp_r[i] <= cmp_nxt[i];
      for (int j = 0; j < 2; j++)
        cap_r[j] <= cap_nxt[j];
      // zero-wait slave: pready in access phase
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
        prdata <= rd_nxt;
      cmp_out <= pin_nxt;
      cmp_oe <= occ_nxt[7:4];
      irq <= |(st_nxt & msk_nxt);
      cap_xfer_req <= cap_hit & msk_r[frt_pkg::ST_CAP0 +: 2];
    end
  end

  a_wrap_flag: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (tick && cnt_r == 16'hffff && !clr_req && !wr) |=> (cnt_r == 16'h0000 && st_r[frt_pkg::ST_OVF]))
    else $error("wrap did not zero count and set overflow");
  a_cap_latch: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cap_hit[0] |=> cap_r[0] == $past(cnt_r))
    else $error("capture 0 missed count");
  a_cap_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !cap_hit[1] |=> $stable(cap_r[1]))
    else $error("capture 1 changed without edge");
  a_match_tgl: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (match[1] && !ctrl_r[frt_pkg::CTRL_PAIR] && !(wr && paddr == frt_pkg::OFF_OCCTRL)) |=> cmp_out[1] != $past(cmp_out[1]))
    else $error("compare 1 pin did not toggle");
  a_clr_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
    clr_req |=> cnt_r == 16'h0000)
    else $error("clear did not zero counter");
  a_halt_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (ctrl_r[frt_pkg::CTRL_HALT] && !wr) |=> $stable(cnt_r))
    else $error("counter moved while halted");
  a_ovf_irq: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r[frt_pkg::ST_OVF] && msk_r[frt_pkg::ST_OVF]) |-> ##[0:1] irq)
    else $error("overflow irq missing");
  a_div4: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (tick && ctrl_r[1:0] == 2'd0 && !ctrl_r[frt_pkg::CTRL_HALT] && !wr) |=> !tick [*3])
    else $error("divide by 4 ticked too soon");
  a_tick_inc: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (tick && !wr && !(match[0] && ctrl_r[frt_pkg::CTRL_CMP0_CLR])) |=> cnt_r == $past(cnt_r) + 16'd1)
    else $error("tick did not advance counter");
  a_cmp0_clr: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (match[0] && ctrl_r[frt_pkg::CTRL_CMP0_CLR]) |=> cnt_r == frt_pkg::COUNT_RST)
    else $error("compare 0 match did not clear counter");
  a_cnt_load: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (wr && paddr == frt_pkg::OFF_COUNT && !(match[0] && ctrl_r[frt_pkg::CTRL_CMP0_CLR]))
      |=> cnt_r == $past(pwdata[15:0]))
    else $error("count write not loaded");
  a_ovf_set: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ev[frt_pkg::ST_OVF] |=> st_r[frt_pkg::ST_OVF])
    else $error("overflow flag not set");
  a_cmp0_flag: assert property (@(posedge clk) disable iff (!rst_sync_n)
    match[0] |=> st_r[frt_pkg::ST_CMP0])
    else $error("compare 0 flag not set");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_sync_n)
    irq == |(st_r & msk_r))
    else $error("irq does not follow status and mask");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (st_r[frt_pkg::ST_CMP0 + 2] && !(wr && paddr == frt_pkg::OFF_STATUS)) |=> st_r[frt_pkg::ST_CMP0 + 2])
    else $error("compare 2 flag dropped without clear");
  sequence s_pair_hit;
    match[0] && !match[1] && ctrl_r[frt_pkg::CTRL_PAIR] && !(wr && paddr == frt_pkg::OFF_OCCTRL);
  endsequence
  sequence s_pin0_flip;
    cmp_out[0] != $past(cmp_out[0]);
  endsequence
  a_pair_shared: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_pair_hit |=> s_pin0_flip)
    else $error("paired match did not toggle pin 0");
  a_pair_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (ctrl_r[frt_pkg::CTRL_PAIR] && !(wr && paddr == frt_pkg::OFF_OCCTRL)) |=> $stable(cmp_out[1]))
    else $error("pin 1 moved in paired mode");
  a_preset_pin: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (wr && paddr == frt_pkg::OFF_OCCTRL) |=> cmp_out == $past(pwdata[3:0]))
    else $error("pin preset not applied");
  a_cap1_latch: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cap_hit[1] |=> cap_r[1] == $past(cnt_r))
    else $error("capture 1 missed count");
  a_rise_only: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (capc_r[1:0] == 2'b01 && !cap_in[0] && capd_r[0]) |=> $stable(cap_r[0]))
    else $error("capture 0 took a falling edge");
  a_both_edge: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (capc_r[3:2] == 2'b11 && cap_in[1] != capd_r[1]) |-> cap_hit[1])
    else $error("capture 1 missed an edge");
  a_xfer_req: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (cap_hit[0] && msk_r[frt_pkg::ST_CAP0]) |=> cap_xfer_req[0])
    else $error("capture 0 transfer request missing");
  a_cap0_hold: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !cap_hit[0] |=> $stable(cap_r[0]))
    else $error("capture 0 changed without edge");
  a_match_once: assert property (@(posedge clk) disable iff (!rst_sync_n)
    match[2] |=> !match[2])
    else $error("compare 2 matched twice in a row");
endmodule : frt_timer
`default_nettype wire

/* verification/frt_pins.sv */
// frt_pins: far-side model that drives the two capture pins
// assumes pin levels are requested by the bench and change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module frt_pins (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] lvl,
  output logic [1:0] cap_in
);
  // pins follow the request one edge later, synchronous to clk
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cap_in <= 2'h0;
    else
      cap_in <= lvl;
  end
endmodule : frt_pins
`default_nettype wire

/* verification/tb.sv */
// tb: self-checking bench for frt_timer over apb
// assumes a 40 MHz clock and the register map of frt_pkg
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic irq;
  logic [1:0] lvl = 2'h0;
  logic [1:0] cap_in;
  logic [1:0] cap_xfer_req;
  logic [3:0] cmp_out;
  logic [3:0] cmp_oe;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  frt_timer frt_timer_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_in(cap_in),
    .cmp_out(cmp_out), .cmp_oe(cmp_oe), .irq(irq), .cap_xfer_req(cap_xfer_req));
  frt_pins frt_pins_inst (.clk(clk), .rst_n(rst_n), .lvl(lvl), .cap_in(cap_in));
  task complete_run;
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  // one apb transfer; read data lands in rd
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task t_reset;
    apb(1'b0, frt_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h4, "ctrl reset");
    apb(1'b0, frt_pkg::OFF_COUNT, 32'h0);
    chk(rd, 32'h0, "count reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask : t_reset
  task t_ovf;
    apb(1'b1, frt_pkg::OFF_COUNT, 32'hffff);
    apb(1'b1, frt_pkg::OFF_MASK, 32'h1);
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h0);
    for (int i = 0; i < 40 && irq !== 1'b1; i++)
      @(posedge clk);
    chk(irq, 32'h1, "overflow irq");
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h4);
    apb(1'b0, frt_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h1, "overflow flag");
    apb(1'b1, frt_pkg::OFF_STATUS, 32'h7f);
    @(posedge clk);
    chk(irq, 32'h0, "irq cleared");
  endtask : t_ovf
  task t_pre;
    int dv [4] = '{4, 16, 32, 64};
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b1, frt_pkg::OFF_CTRL, 32'hc);
      apb(1'b0, frt_pkg::OFF_COUNT, 32'h0);
      chk(rd, 32'h0, "clear");
      apb(1'b1, frt_pkg::OFF_CTRL, p);
      repeat (dv[p] * 8) @(posedge clk);
      apb(1'b1, frt_pkg::OFF_CTRL, 32'h4);
      apb(1'b0, frt_pkg::OFF_COUNT, 32'h0);
      chk(rd >= 8 && rd <= 9, 32'h1, "prescale");
    end
  endtask : t_pre
  task t_cmp;
    apb(1'b1, frt_pkg::OFF_OCCTRL, 32'hf5);
    @(posedge clk);
    chk({cmp_oe, cmp_out}, 32'hf5, "preset");
    apb(1'b1, frt_pkg::OFF_COUNT, 32'h10);
    apb(1'b1, frt_pkg::OFF_CMP0 + 8'h8, 32'h12);
    apb(1'b1, frt_pkg::OFF_MASK, 32'h8);
    apb(1'b1, frt_pkg::OFF_STATUS, 32'h7f);
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h0);
    for (int i = 0; i < 60 && irq !== 1'b1; i++)
      @(posedge clk);
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h4);
    chk(cmp_out, 32'h1, "single toggle");
    apb(1'b0, frt_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h8, "own flag");
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h24);
    apb(1'b1, frt_pkg::OFF_COUNT, 32'h10);
    apb(1'b1, frt_pkg::OFF_CMP0, 32'h11);
    apb(1'b1, frt_pkg::OFF_CMP0 + 8'h4, 32'h13);
    apb(1'b1, frt_pkg::OFF_MASK, 32'h4);
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h20);
    for (int i = 0; i < 60 && irq !== 1'b1; i++)
      @(posedge clk);
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h4);
    chk(cmp_out, 32'h5, "paired pins");
  endtask : t_cmp
  task t_clr0;
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h14);
    apb(1'b1, frt_pkg::OFF_COUNT, 32'h0);
    apb(1'b1, frt_pkg::OFF_CMP0, 32'h5);
    apb(1'b1, frt_pkg::OFF_MASK, 32'h2);
    apb(1'b1, frt_pkg::OFF_STATUS, 32'h7f);
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h10);
    repeat (200) @(posedge clk);
    chk(irq, 32'h1, "compare 0 irq");
    apb(1'b0, frt_pkg::OFF_COUNT, 32'h0);
    chk(rd <= 5, 32'h1, "compare 0 clear");
    apb(1'b1, frt_pkg::OFF_CTRL, 32'h4);
    apb(1'b0, frt_pkg::OFF_STATUS, 32'h0);
    chk(rd & 32'h2, 32'h2, "compare 0 flag");
  endtask : t_clr0
  task t_cap;
    apb(1'b1, frt_pkg::OFF_STATUS, 32'h7f);
    apb(1'b1, frt_pkg::OFF_COUNT, 32'h1234);
    apb(1'b1, frt_pkg::OFF_CAPCTRL, 32'h1);
    apb(1'b1, frt_pkg::OFF_MASK, 32'h20);
    lvl <= 2'h1;
    for (int i = 0; i < 40 && cap_xfer_req[0] !== 1'b1; i++)
      @(posedge clk);
    chk(cap_xfer_req, 32'h1, "xfer request");
    chk(irq, 32'h1, "capture irq");
    apb(1'b0, frt_pkg::OFF_CAP0, 32'h0);
    chk(rd, 32'h1234, "capture");
    apb(1'b1, frt_pkg::OFF_COUNT, 32'h5678);
    lvl <= 2'h0;
    repeat (5) @(posedge clk);
    apb(1'b1, frt_pkg::OFF_CAP0, 32'hbeef);
    chk(err, 32'h0, "capture write error");
    apb(1'b0, frt_pkg::OFF_CAP0, 32'h0);
    chk(rd, 32'h1234, "capture held");
    apb(1'b1, frt_pkg::OFF_CAPCTRL, 32'hc);
    for (int e = 0; e < 2; e++)
    begin
      apb(1'b1, frt_pkg::OFF_COUNT, 32'h40 + e);
      lvl[1] <= ~lvl[1];
      repeat (5) @(posedge clk);
      apb(1'b0, frt_pkg::OFF_CAP0 + 8'h4, 32'h0);
      chk(rd, 32'h40 + e, "both edges");
    end
  endtask : t_cap
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_ovf();
    t_pre();
    t_cmp();
    t_clr0();
    t_cap();
    complete_run();
  end
endmodule : tb
`default_nettype wire
